// ---- rtl/psd_pkg.sv ----
// Constants and types shared by the press setup drive permit block
package psd_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned MIN_SHORT_MS    = 100;
	localparam int unsigned MIN_LONG_MS     = 350;
	localparam int unsigned MAX_PULSE_MS    = 30_000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned MIN_SHORT_CYC   = MIN_SHORT_MS * CYC_PER_MS;
	localparam int unsigned MIN_LONG_CYC    = MIN_LONG_MS * CYC_PER_MS;
	localparam int unsigned MAX_PULSE_CYC   = MAX_PULSE_MS * CYC_PER_MS;
	localparam int unsigned CNT_W           = 29;
	localparam logic        PERMIT_RST      = 1'b0;
	localparam logic        PENDING_RST     = 1'b1;
	// Command stage resets high so a command held through reset is no start
	localparam logic [4:0]  SYNC_RST        = 5'h04;

	typedef enum logic [1:0] {
		PSD_IL_NEVER  = 2'b00,
		PSD_IL_STATIC = 2'b01,
		PSD_IL_TOP    = 2'b10,
		PSD_IL_ALWAYS = 2'b11
	} psd_ilock_t;

	typedef enum logic [1:0] {
		PSD_RA_LOW  = 2'b00,
		PSD_RA_HIGH = 2'b01,
		PSD_RA_OVER = 2'b10
	} psd_rearm_t;
endpackage : psd_pkg

// ---- rtl/psd_rearm.sv ----
// Rearm pulse width checker: reports a valid 0-1-0 pulse
`timescale 1ns/10ps
module psd_rearm #(
	parameter int unsigned MIN_SHORT = psd_pkg::MIN_SHORT_CYC,
	parameter int unsigned MIN_LONG  = psd_pkg::MIN_LONG_CYC,
	parameter int unsigned MAX_CYC   = psd_pkg::MAX_PULSE_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pulse_in,
	input  wire logic long_sel,
	output logic      valid
);
	localparam int unsigned W = psd_pkg::CNT_W;
	localparam logic [W-1:0] MIN_S = W'(MIN_SHORT);
	localparam logic [W-1:0] MIN_L = W'(MIN_LONG);
	localparam logic [W-1:0] MAX_C = W'(MAX_CYC);

	// Limits the counter cannot hold are refused while elaborating
	if (MIN_SHORT < 1 || MIN_LONG < 1 || MAX_CYC <= MIN_LONG ||
		MAX_CYC <= MIN_SHORT || MAX_CYC >= (1 << W)) begin : g_bad_lim
		$error("psd_rearm: pulse limits unusable");
	end

	psd_pkg::psd_rearm_t state_reg;
	logic [W-1:0]        cnt_reg;
	logic [W-1:0]        min_lim;

	// Limit picked from the live selection, counted in cycles
	assign min_lim = long_sel ? MIN_L : MIN_S;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= psd_pkg::PSD_RA_LOW;
		end else begin
			unique case (state_reg)
			psd_pkg::PSD_RA_LOW: begin
				if (pulse_in) begin
					state_reg <= psd_pkg::PSD_RA_HIGH;
				end
			end
			psd_pkg::PSD_RA_HIGH: begin
				if (!pulse_in) begin
					state_reg <= psd_pkg::PSD_RA_LOW;
				end else if (cnt_reg >= MAX_C) begin
					state_reg <= psd_pkg::PSD_RA_OVER;
				end
			end
			psd_pkg::PSD_RA_OVER: begin
				if (!pulse_in) begin
					state_reg <= psd_pkg::PSD_RA_LOW;
				end
			end
			default: begin
				state_reg <= psd_pkg::PSD_RA_LOW;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (state_reg == psd_pkg::PSD_RA_HIGH && pulse_in) begin
			cnt_reg <= cnt_reg + W'(1);
		end else if (state_reg != psd_pkg::PSD_RA_HIGH) begin
			cnt_reg <= W'(1);
		end
	end

	// Falling edge after an in-range high phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
		end else begin
			valid <= state_reg == psd_pkg::PSD_RA_HIGH && !pulse_in &&
				cnt_reg >= min_lim && cnt_reg <= MAX_C;
		end
	end
endmodule : psd_rearm

// ---- rtl/psd_top.sv ----
// Press setup drive permit: combines permits into one drive enable
`timescale 1ns/10ps
module psd_top #(
	parameter int unsigned MIN_SHORT = psd_pkg::MIN_SHORT_CYC,
	parameter int unsigned MIN_LONG  = psd_pkg::MIN_LONG_CYC,
	parameter int unsigned MAX_CYC   = psd_pkg::MAX_PULSE_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       STATIC_PERMIT,
	input  wire logic       START_PERMIT,
	input  wire logic       START_STOP,
	input  wire logic       CYCLE_END,
	input  wire logic       REARM,
	input  wire logic [1:0] CFG_ILOCK,
	input  wire logic       CFG_START_USED,
	input  wire logic       CFG_STROKE_MON,
	input  wire logic       CFG_MIN_LONG,
	output logic            DRIVE_PERMIT,
	output logic            REARM_PENDING,
	output logic            STATIC_PERMIT_N
);
	// Rearm limits must order short, long, ceiling within the counter
	if (MIN_SHORT < 1 || MIN_LONG < MIN_SHORT || MAX_CYC <= MIN_LONG ||
		MAX_CYC >= (1 << psd_pkg::CNT_W)) begin : g_bad_lim
		$error("psd_top: rearm limits unusable");
	end

	// Pins pass two flip-flops before any logic looks at them
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] pins;

	assign pins = {REARM, CYCLE_END, START_STOP, START_PERMIT,
		STATIC_PERMIT};

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_reg <= psd_pkg::SYNC_RST;
			sync2_reg <= psd_pkg::SYNC_RST;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	logic static_ok;
	logic start_ok;
	logic cmd;
	logic top;
	logic rearm_s;
	logic cmd_d_reg;
	logic top_d_reg;

	assign static_ok = sync2_reg[0];
	assign start_ok  = sync2_reg[1];
	assign cmd       = sync2_reg[2];
	assign top       = sync2_reg[3];
	assign rearm_s   = sync2_reg[4];

	// Edge detectors read the second stage only; command starts high-held
	// at reset so a level already high is not taken as a start
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_d_reg <= 1'b1;
			top_d_reg <= 1'b1;
		end else begin
			cmd_d_reg <= cmd;
			top_d_reg <= top;
		end
	end

	logic cmd_rise;
	logic top_rise;

	assign cmd_rise = cmd && !cmd_d_reg;
	assign top_rise = top && !top_d_reg;

	psd_pkg::psd_ilock_t ilock;
	assign ilock = psd_pkg::psd_ilock_t'(CFG_ILOCK);

	// Stop causes for the current cycle
	logic stop_static;
	logic stop_cmd;
	logic stop_top;
	logic stopping;

	assign stop_static = !static_ok;
	assign stop_cmd    = !cmd;
	assign stop_top    = CFG_STROKE_MON && top_rise;

	logic permit_reg;
	logic permit_next;
	logic pending_reg;
	logic pending_next;
	logic rearm_ok;
	logic start_req;
	logic lock_hit;

	assign stopping = permit_reg && (stop_static || stop_cmd || stop_top);

	// Which stops arm the interlock
	always_comb begin
		lock_hit = 1'b0;
		unique case (ilock)
		psd_pkg::PSD_IL_NEVER: begin
			lock_hit = 1'b0;
		end
		psd_pkg::PSD_IL_STATIC: begin
			lock_hit = stop_static || stop_cmd;
		end
		psd_pkg::PSD_IL_TOP: begin
			lock_hit = stop_static || stop_top;
		end
		psd_pkg::PSD_IL_ALWAYS: begin
			lock_hit = 1'b1;
		end
		endcase
	end

	psd_rearm #(
		.MIN_SHORT(MIN_SHORT),
		.MIN_LONG (MIN_LONG),
		.MAX_CYC  (MAX_CYC)
	) u_rearm (
		.clk     (CLK),
		.rst_n   (RST_N),
		.pulse_in(rearm_s),
		.long_sel(CFG_MIN_LONG),
		.valid   (rearm_ok)
	);

	// Start gating is the same in both stroke modes; the stroke mode only
	// decides whether cycle-end ends the permit
	assign start_req = cmd_rise && static_ok && !pending_reg &&
		(!CFG_START_USED || start_ok);

	always_comb begin
		permit_next = permit_reg;
		if (stop_static) begin
			permit_next = 1'b0;
		end else if (permit_reg) begin
			if (stop_cmd || stop_top) begin
				permit_next = 1'b0;
			end
			// Start permit no longer looked at while running
		end else if (start_req) begin
			permit_next = 1'b1;
		end
	end

	// Interlock arm wins over a rearm arriving in the same cycle
	always_comb begin
		pending_next = pending_reg;
		if (rearm_ok) begin
			pending_next = 1'b0;
		end
		if (stopping && lock_hit) begin
			pending_next = 1'b1;
		end
		if (ilock == psd_pkg::PSD_IL_NEVER) begin
			pending_next = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			permit_reg <= psd_pkg::PERMIT_RST;
		end else begin
			permit_reg <= permit_next;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pending_reg <= psd_pkg::PENDING_RST;
		end else begin
			pending_reg <= pending_next;
		end
	end

	// Combinational gate so a static drop cuts the drive as soon as the second sync stage shows it
	assign DRIVE_PERMIT    = permit_reg && static_ok;
	assign REARM_PENDING   = pending_reg;
	assign STATIC_PERMIT_N = !static_ok;
endmodule : psd_top

// ---- sim/psd_checker.sv ----
// Port assertions for the drive permit block
`timescale 1ns/10ps
module psd_checker (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       STATIC_PERMIT,
	input wire logic       START_PERMIT,
	input wire logic       START_STOP,
	input wire logic       CYCLE_END,
	input wire logic       REARM,
	input wire logic [1:0] CFG_ILOCK,
	input wire logic       CFG_START_USED,
	input wire logic       CFG_STROKE_MON,
	input wire logic       DRIVE_PERMIT,
	input wire logic       REARM_PENDING,
	input wire logic       STATIC_PERMIT_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	static_drop_a: assert property (
		!STATIC_PERMIT[*2] |=> !DRIVE_PERMIT) else $error("static drop");
	start_gate_a: assert property (
		$rose(DRIVE_PERMIT) && CFG_START_USED |-> $past(START_PERMIT, 3))
		else $error("start permit gate");
	stroke_end_a: assert property (
		CFG_STROKE_MON && $rose(CYCLE_END) |-> ##[1:4] !DRIVE_PERMIT)
		else $error("cycle end stop");
	never_free_a: assert property (
		CFG_ILOCK == 2'h0 ##1 CFG_ILOCK == 2'h0 |=> !REARM_PENDING)
		else $error("pending with no interlock");
	rearm_width_a: assert property (
		$fell(REARM_PENDING) && CFG_ILOCK != 2'h0
		|-> $past(REARM, 8) && !$past(REARM)) else $error("rearm width");
	pend_block_a: assert property (
		$rose(DRIVE_PERMIT) |-> !$past(REARM_PENDING))
		else $error("start while pending");
	inv_static_a: assert property (
		STATIC_PERMIT[*3] |=> !STATIC_PERMIT_N) else $error("inverse out");
	cmd_stop_a: assert property (
		!START_STOP[*3] |=> !DRIVE_PERMIT) else $error("command stop");
	cover property ($rose(DRIVE_PERMIT));
	cover property ($fell(REARM_PENDING));
	cover property (CFG_STROKE_MON && $rose(CYCLE_END));
endmodule : psd_checker

// ---- sim/psd_far.sv ----
// Far-side model: two-hand control giving timed rearm pulses
`timescale 1ns/10ps
module psd_far (
	input wire logic       clk,
	input wire logic       go,
	input wire logic [7:0] len,
	output logic           rearm
);
	logic [7:0] left_reg = 8'h00;
	// Clean 0-1-0 of exactly len cycles, no bounce
	always @(posedge clk) begin
		if (go)
			left_reg <= len;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
	end
	assign rearm = (left_reg != 8'h00);
endmodule : psd_far

// ---- sim/psd_top_tb.sv ----
// Self-checking bench for the drive permit block
`timescale 1ns/10ps
module psd_top_tb;
	logic clk = 0, rst_n = 0, sp = 1, st = 1, ss = 0, ce = 0;
	logic cu = 1, sm = 0, ml = 0, go = 0, rearm, dp, rp, spn;
	logic [1:0] il = 2'h0;
	logic [7:0] len = 8'h00;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	// Short limits keep each rearm pulse at most a few tens of cycles long
	psd_top #(.MIN_SHORT(10), .MIN_LONG(20), .MAX_CYC(50)) dut (
		.CLK(clk), .RST_N(rst_n), .STATIC_PERMIT(sp), .START_PERMIT(st),
		.START_STOP(ss), .CYCLE_END(ce), .REARM(rearm), .CFG_ILOCK(il),
		.CFG_START_USED(cu), .CFG_STROKE_MON(sm), .CFG_MIN_LONG(ml),
		.DRIVE_PERMIT(dp), .REARM_PENDING(rp), .STATIC_PERMIT_N(spn));
	psd_far far (.clk(clk), .go(go), .len(len), .rearm(rearm));
	initial forever #50 clk = ~clk;
	task tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : tick
	task chk(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	task pulse(input int n);
		len = 8'(n);
		go = 1;
		tick(1);
		go = 0;
		tick(n + 10);
	endtask : pulse
	task t_never;
		chk("pend", 1'b0, rp);
		ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		st = 0; tick(5);
		chk("permit", 1'b1, dp);
		ss = 0; tick(5);
		chk("permit", 1'b0, dp);
		chk("pend", 1'b0, rp);
		ss = 1; tick(5);
		chk("permit", 1'b0, dp);
		st = 1; ss = 0; tick(4); ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		sp = 0; tick(3);
		chk("permit", 1'b0, dp);
		chk("spn", 1'b1, spn);
		sp = 1; ss = 0; tick(4);
		chk("spn", 1'b0, spn);
	endtask : t_never
	task t_rearm;
		il = 2'h1; ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		ss = 0; tick(5);
		chk("pend", 1'b1, rp);
		pulse(5);
		chk("pend", 1'b1, rp);
		pulse(51);
		chk("pend", 1'b1, rp);
		pulse(10);
		chk("pend", 1'b0, rp);
		ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		ml = 1; ss = 0; tick(5);
		chk("pend", 1'b1, rp);
		pulse(19);
		chk("pend", 1'b1, rp);
		pulse(50);
		chk("pend", 1'b0, rp);
	endtask : t_rearm
	task t_stroke;
		il = 2'h2; sm = 1; ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		ce = 1; tick(5);
		chk("permit", 1'b0, dp);
		chk("pend", 1'b1, rp);
		ce = 0; ss = 0; pulse(20);
		chk("pend", 1'b0, rp);
		il = 2'h3; ss = 1; tick(5);
		chk("permit", 1'b1, dp);
		ss = 0; tick(5);
		chk("pend", 1'b1, rp);
	endtask : t_stroke
	task t_options;
		il = 2'h0;
		cu = 0;
		sm = 0;
		st = 0;
		tick(5);
		chk("pend", 1'b0, rp);
		ss = 1;
		tick(5);
		chk("permit", 1'b1, dp);
		ce = 1;
		tick(5);
		chk("permit", 1'b1, dp);
		ce = 0;
		st = 1;
		tick(2);
	endtask : t_options
	task t_reset;
		rst_n = 0;
		tick(2);
		chk("permit", 1'b0, dp);
		chk("pend", 1'b1, rp);
		rst_n = 1;
		tick(6);
		chk("permit", 1'b0, dp);
		chk("pend", 1'b0, rp);
		ss = 0;
		tick(4);
		ss = 1;
		tick(5);
		chk("permit", 1'b1, dp);
	endtask : t_reset
	task tally_and_finish;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		tick(4);
		rst_n = 1;
		tick(4);
		t_never();
		t_rearm();
		t_stroke();
		t_options();
		t_reset();
		tally_and_finish();
	end
endmodule : psd_top_tb
bind psd_top psd_checker chk_i (.CLK(CLK), .RST_N(RST_N),
	.STATIC_PERMIT(STATIC_PERMIT), .START_PERMIT(START_PERMIT),
	.START_STOP(START_STOP), .CYCLE_END(CYCLE_END), .REARM(REARM),
	.CFG_ILOCK(CFG_ILOCK), .CFG_START_USED(CFG_START_USED),
	.CFG_STROKE_MON(CFG_STROKE_MON), .DRIVE_PERMIT(DRIVE_PERMIT),
	.REARM_PENDING(REARM_PENDING), .STATIC_PERMIT_N(STATIC_PERMIT_N));
